// ---- shared/pin_io_pkg.sv ----
// Purpose : Shared constants for the three-pin configurable I/O port
// Assumes : 40 MHz system clock, debounce timed from a slower internal oscillator tick
// Notes   : All timing counts are derived here from printed times
package pin_io_pkg;
  localparam int unsigned NUM_PINS          = 3;
  localparam int unsigned CLK_HZ            = 40_000_000;
  // Dedicated oscillator rate that times the debounce interval
  localparam int unsigned OSC_HZ            = 32_768;
  localparam int unsigned INPUT_DEBOUNCE_MS = 30;
  // Clock cycles per oscillator tick, rounded down
  localparam int unsigned OSC_DIV           = CLK_HZ / OSC_HZ;
  // Oscillator ticks for the debounce time, rounded up
  localparam int unsigned DEBOUNCE_TICKS    = (INPUT_DEBOUNCE_MS * OSC_HZ + 999) / 1000;
  // Pin indices with alternate functions
  localparam int unsigned PIN_ZERO          = 0;
  localparam int unsigned PIN_ONE           = 1;
  localparam int unsigned PIN_TWO           = 2;
  // Rail-two enable field codes that make the rail follow pin one
  localparam logic [2:0]  RAIL_PIN_CODE_A   = 3'h4;
  localparam logic [2:0]  RAIL_PIN_CODE_B   = 3'h5;
  // Reset values
  localparam logic        MASK_RESET        = 1'h1;
  localparam logic        LEVEL_RESET       = 1'h0;
endpackage

// ---- shared/edge_evt_if.sv ----
// Purpose : Carries debounced levels and edge events from the filter to the port top
// Assumes : Single clock domain
// Notes   : Events are one-cycle pulses
`timescale 1ns/10ps
interface edge_evt_if;
  logic level;   // Debounced or bypassed level
  logic rise;    // Rising edge pulse
  logic fall;    // Falling edge pulse
  modport source (output level, output rise, output fall);
  modport sink   (input level, input rise, input fall);
endinterface : edge_evt_if

// ---- rtl/osc_tick.sv ----
// Purpose : Slow timebase standing in for the dedicated debounce oscillator
// Assumes : Synchronous active-high reset
// Notes   : One-cycle tick every DIV clocks
`timescale 1ns/10ps
module osc_tick #(
  parameter int unsigned DIV = pin_io_pkg::OSC_DIV
) (
  input  wire logic clk_i,    // System clock
  input  wire logic reset_i,  // Synchronous reset
  output logic      tick_o    // Oscillator tick pulse
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } state_s;
  state_s s_q;
  state_s s_d;

  // Free-running divider; debounce stays independent of host bus timing
  always_comb
  begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 16'(DIV - 1))
    begin
      s_d.cnt  = 16'h0000;
      s_d.tick = 1'b1;
    end
    else
      s_d.cnt = s_q.cnt + 16'h0001;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick_o = s_q.tick;
endmodule // osc_tick

// ---- rtl/pin_filter.sv ----
// Purpose : Synchronise, optionally debounce, and edge-detect one input pin
// Assumes : Tick from the dedicated oscillator timebase
// Notes   : With debounce on, level changes only after the raw level holds TICKS ticks
`timescale 1ns/10ps
module pin_filter #(
  parameter int unsigned TICKS = pin_io_pkg::DEBOUNCE_TICKS
) (
  input  wire logic clk_i,    // System clock
  input  wire logic reset_i,  // Synchronous reset
  input  wire logic pin_i,    // Raw pin level
  input  wire logic dben_i,   // Debounce enable
  input  wire logic tick_i,   // Oscillator tick
  edge_evt_if.source evt      // Level and edges
);
  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        lvl;
    logic [11:0] cnt;
    logic        rise;
    logic        fall;
  } state_s;
  state_s s_q;
  state_s s_d;

  // Two-stage sync, then filter; edges come from the filtered level only
  always_comb
  begin
    s_d      = s_q;
    s_d.s1   = pin_i;
    s_d.s2   = s_q.s1;
    s_d.rise = 1'b0;
    s_d.fall = 1'b0;
    if (!dben_i)
    begin
      s_d.lvl = s_q.s2;
      s_d.cnt = 12'h000;
    end
    else if (s_q.s2 == s_q.lvl)
      s_d.cnt = 12'h000;
    else if (tick_i)
    begin
      if (s_q.cnt == 12'(TICKS - 1))
      begin
        s_d.lvl = s_q.s2;
        s_d.cnt = 12'h000;
      end
      else
        s_d.cnt = s_q.cnt + 12'h001;
    end
    s_d.rise = s_d.lvl & ~s_q.lvl;
    s_d.fall = ~s_d.lvl & s_q.lvl;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign evt.level = s_q.lvl;
  assign evt.rise  = s_q.rise;
  assign evt.fall  = s_q.fall;

  // Every level change gives exactly one event, and no event comes without one
  AST_ONE_EDGE: assert property (@(posedge clk_i) disable iff (reset_i)
    $changed(s_q.lvl) == (s_q.rise ^ s_q.fall)) else $error("level change without exactly one event");
  AST_BYPASS: assert property (@(posedge clk_i) disable iff (reset_i)
    (!dben_i && $rose(s_q.s2)) |=> s_q.rise) else $error("bypass edge missed");
endmodule // pin_filter

// ---- rtl/pin_io_port.sv ----
// Purpose : Three configurable pins with edge interrupts and alternate functions
// Assumes : Configuration bits arrive as plain ports held by a register block outside
// Notes   : Software clears sticky edge flags by pulsing the clear inputs
// Overview of operation
// - A direction bit of zero makes the pin an output, one makes it an input.
// - An output drives both levels when drive type is one and only pulls low when it is zero.
// - The input level bit follows the pin even while the pin is an output.
// - With debounce enabled the input's edges and alternate uses pass a 30 ms filter, otherwise they go straight through; the level bit is never filtered.
// - The debounce interval is timed from a dedicated oscillator timebase.
// - Rising and falling edges of each input are detected separately and flagged.
// - An edge interrupts only when its mask bit is zero.
// - Each pin has a readable alternate-mode select bit.
// - Pin zero in alternate mode drives the sequencer slot of rail two, active high.
// - Pin one in alternate mode is an active-high enable for rail two, replacing the sequencer enable.
// - With pin one alternate, enable codes 4 and 5 follow the pin, all other codes keep the rail on.
// - Pin two in alternate mode is ORed with the bias low-power bit to request low power.
// - The active-low interrupt output is the NOR of all unmasked interrupt bits.
// - After reset all interrupt masks are set.
`timescale 1ns/10ps
module pin_io_port #(
  parameter int unsigned N     = pin_io_pkg::NUM_PINS,
  parameter int unsigned TICKS = pin_io_pkg::DEBOUNCE_TICKS,
  parameter int unsigned DIV   = pin_io_pkg::OSC_DIV
) (
  input  wire logic         clk_i,                 // 40 MHz clock
  input  wire logic         reset_i,               // Synchronous reset
  input  wire logic [N-1:0] pin_in_i,              // Pin input level
  output logic      [N-1:0] pin_out_o,             // Pin output level
  output logic      [N-1:0] pin_oe_o,              // Pin output enable
  input  wire logic [N-1:0] pin_dir_i,             // 0 output, 1 input
  input  wire logic [N-1:0] pin_drive_type_i,      // 1 push-pull, 0 open-drain
  input  wire logic [N-1:0] pin_out_val_i,         // Output data
  input  wire logic [N-1:0] input_debounce_en_i,   // Debounce enable
  input  wire logic [N-1:0] pin_alt_select_i,      // Alternate mode select
  input  wire logic [N-1:0] input_rise_mask_i,     // Rising mask, written value
  input  wire logic [N-1:0] input_fall_mask_i,     // Falling mask, written value
  input  wire logic         mask_we_i,             // Load both masks
  input  wire logic [N-1:0] rise_clr_i,            // Clear rising flags
  input  wire logic [N-1:0] fall_clr_i,            // Clear falling flags
  input  wire logic [2:0]   rail_two_enable_field_i, // Rail two enable code
  input  wire logic         power_sequencer_slot_i,  // Sequencer slot for rail two
  input  wire logic         power_sequencer_en_i,    // Sequencer enables rail two
  input  wire logic         bias_low_power_bit_i,    // Register low-power bit
  input  wire logic         other_irq_i,           // Other unmasked interrupt sources
  output logic      [N-1:0] pin_input_level_o,     // Input status
  output logic      [N-1:0] pin_alt_select_o,      // Alternate mode readback
  output logic      [N-1:0] rise_flag_o,           // Sticky rising flags
  output logic      [N-1:0] fall_flag_o,           // Sticky falling flags
  output logic      [N-1:0] rise_mask_o,           // Current rising masks
  output logic      [N-1:0] fall_mask_o,           // Current falling masks
  output logic              rail_two_on_o,         // Rail two enabled
  output logic              bias_low_power_req_o,  // Low-power request
  output logic              irq_out_n_o,           // Interrupt, active low level
  output logic              irq_out_oe_o           // Interrupt open-drain enable
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [N-1:0] rmask;
    logic [N-1:0] fmask;
    logic [N-1:0] rflag;
    logic [N-1:0] fflag;
    logic [N-1:0] lvl_s1;
    logic [N-1:0] lvl_s2;
    logic [N-1:0] out;
    logic [N-1:0] oe;
    logic         rail;
    logic         lpm;
    logic         irq_n;
    logic [N-1:0] alt;
  } state_s;
  state_s s_q;
  state_s s_d;

  logic         tick;
  logic [N-1:0] lvl;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  logic [N-1:0] dben;

  ////////////////////////////////////////////////////////////////////////////
  // Shared oscillator timebase for all debounce filters
  osc_tick #(.DIV(DIV)) u_tick (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .tick_o  (tick)
  );

  // One filter per pin; alternate inputs are filtered too for clean levels
  for (genvar g = 0; g < N; g++)
  begin : g_pin
    edge_evt_if e ();
    // Filter only when the pin is an input with debounce on
    assign dben[g] = pin_dir_i[g] & input_debounce_en_i[g];
    pin_filter #(.TICKS(TICKS)) u_filt (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .pin_i   (pin_in_i[g]),
      .dben_i  (dben[g]),
      .tick_i  (tick),
      .evt     (e.source)
    );
    assign lvl[g]  = e.level;
    assign rise[g] = e.rise & pin_dir_i[g];
    assign fall[g] = e.fall & pin_dir_i[g];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for pins, flags, masks and alternate functions
  always_comb
  begin
    s_d        = s_q;
    s_d.alt    = pin_alt_select_i;
    s_d.lvl_s1 = pin_in_i;
    s_d.lvl_s2 = s_q.lvl_s1;
    if (mask_we_i)
    begin
      s_d.rmask = input_rise_mask_i;
      s_d.fmask = input_fall_mask_i;
    end
    // Set wins over clear so no edge is lost
    s_d.rflag = (s_q.rflag & ~rise_clr_i) | rise;
    s_d.fflag = (s_q.fflag & ~fall_clr_i) | fall;
    for (int i = 0; i < N; i++)
    begin
      if (pin_alt_select_i[i] && i == pin_io_pkg::PIN_ZERO)
      begin
        s_d.out[i] = power_sequencer_slot_i;
        s_d.oe[i]  = 1'b1;
      end
      else if (pin_alt_select_i[i] || pin_dir_i[i])
      begin
        s_d.out[i] = 1'b0;
        s_d.oe[i]  = 1'b0;
      end
      else if (pin_drive_type_i[i])
      begin
        s_d.out[i] = pin_out_val_i[i];
        s_d.oe[i]  = 1'b1;
      end
      else
      begin
        s_d.out[i] = 1'b0;
        s_d.oe[i]  = ~pin_out_val_i[i];
      end
    end
    // Rail two: with pin one alternate, codes 4 and 5 follow pin one and others stay on; otherwise it follows the sequencer enable
    if (pin_alt_select_i[pin_io_pkg::PIN_ONE])
    begin
      if (rail_two_enable_field_i == pin_io_pkg::RAIL_PIN_CODE_A ||
          rail_two_enable_field_i == pin_io_pkg::RAIL_PIN_CODE_B)
        s_d.rail = lvl[pin_io_pkg::PIN_ONE];
      else
        s_d.rail = 1'b1;
    end
    else
      s_d.rail = power_sequencer_en_i;
    if (pin_alt_select_i[pin_io_pkg::PIN_ONE] && lvl[pin_io_pkg::PIN_ONE])
      s_d.rail = 1'b1;
    s_d.lpm = bias_low_power_bit_i |
              (pin_alt_select_i[pin_io_pkg::PIN_TWO] & lvl[pin_io_pkg::PIN_TWO]);
    // NOR of all unmasked bits, from the next flag and mask state
    s_d.irq_n = ~(|(s_d.rflag & ~s_d.rmask) | |(s_d.fflag & ~s_d.fmask) | other_irq_i);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; masks come out of reset set
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s_q       <= '0;
      s_q.rmask <= {N{pin_io_pkg::MASK_RESET}};
      s_q.fmask <= {N{pin_io_pkg::MASK_RESET}};
      s_q.irq_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; interrupt pin drives low only, external pull-up gives high
  assign pin_out_o            = s_q.out;
  assign pin_oe_o             = s_q.oe;
  assign pin_input_level_o    = s_q.lvl_s2;
  assign pin_alt_select_o     = s_q.alt;
  assign rise_flag_o          = s_q.rflag;
  assign fall_flag_o          = s_q.fflag;
  assign rise_mask_o          = s_q.rmask;
  assign fall_mask_o          = s_q.fmask;
  assign rail_two_on_o        = s_q.rail;
  assign bias_low_power_req_o = s_q.lpm;
  assign irq_out_n_o          = 1'b0;
  assign irq_out_oe_o         = ~s_q.irq_n;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Masks and the interrupt pin; reset leaves every mask set
  AST_MASK_RESET: assert property (@(posedge clk_i)
    $fell(reset_i) |-> (&s_q.rmask && &s_q.fmask)) else $error("masks not set after reset");
  AST_MASKED_QUIET: assert property (@(posedge clk_i) disable iff (reset_i)
    (&s_q.rmask && &s_q.fmask && !other_irq_i && !mask_we_i) |=> !irq_out_oe_o) else $error("masked irq");
  AST_IRQ_NOR: assert property (@(posedge clk_i) disable iff (reset_i)
    ##1 (irq_out_oe_o == (|(s_q.rflag & ~s_q.rmask) | |(s_q.fflag & ~s_q.fmask) | $past(other_irq_i))))
    else $error("irq not NOR of unmasked bits");
  AST_MASK_LOAD: assert property (@(posedge clk_i) disable iff (reset_i)
    mask_we_i |=> (rise_mask_o == $past(input_rise_mask_i) && fall_mask_o == $past(input_fall_mask_i)))
    else $error("masks not loaded");

  // Flags are sticky; a clear only wins when no edge arrives with it
  AST_RISE_FLAG: assert property (@(posedge clk_i) disable iff (reset_i)
    rise[0] |=> rise_flag_o[0]) else $error("rising flag lost");
  AST_FALL_FLAG: assert property (@(posedge clk_i) disable iff (reset_i)
    fall[1] |=> fall_flag_o[1]) else $error("falling flag lost");
  AST_FLAG_STICKY: assert property (@(posedge clk_i) disable iff (reset_i)
    (rise_flag_o[2] && !rise_clr_i[2]) |=> rise_flag_o[2]) else $error("rising flag dropped without clear");
  AST_FLAG_CLEAR: assert property (@(posedge clk_i) disable iff (reset_i)
    (rise_clr_i[0] && !rise[0]) |=> !rise_flag_o[0]) else $error("rising flag not cleared");

  // Pin drive and readback follow direction, drive type and alternate select one clock later; status follows the pin two clocks later
  AST_STATUS: assert property (@(posedge clk_i) disable iff (reset_i)
    ##2 (pin_input_level_o == $past(pin_in_i, 2))) else $error("status not following pin");
  AST_DIR_IN: assert property (@(posedge clk_i) disable iff (reset_i)
    ##1 ((pin_oe_o & $past(pin_dir_i & ~pin_alt_select_i)) == '0)) else $error("input pin driven");
  AST_PUSH_PULL: assert property (@(posedge clk_i) disable iff (reset_i)
    (!pin_dir_i[0] && !pin_alt_select_i[0] && pin_drive_type_i[0])
    |=> (pin_oe_o[0] && pin_out_o[0] == $past(pin_out_val_i[0]))) else $error("push-pull output wrong");
  AST_OPEN_DRAIN: assert property (@(posedge clk_i) disable iff (reset_i)
    pin_oe_o[2] && !pin_alt_select_i[2] && !$past(pin_drive_type_i[2]) |-> !pin_out_o[2])
    else $error("open drain drove high");
  AST_READBACK: assert property (@(posedge clk_i) disable iff (reset_i)
    ##1 (pin_alt_select_o == $past(pin_alt_select_i))) else $error("alternate select readback wrong");
  AST_ALT0: assert property (@(posedge clk_i) disable iff (reset_i)
    pin_alt_select_i[0] |=> (pin_oe_o[0] && pin_out_o[0] == $past(power_sequencer_slot_i)))
    else $error("pin zero alternate output wrong");

  // Rail two and the low-power request
  AST_RAIL: assert property (@(posedge clk_i) disable iff (reset_i)
    (pin_alt_select_i[1] && rail_two_enable_field_i[2:1] != 2'h2) |=> rail_two_on_o)
    else $error("rail two dropped");
  AST_RAIL_OFF: assert property (@(posedge clk_i) disable iff (reset_i)
    (pin_alt_select_i[1] && rail_two_enable_field_i[2:1] == 2'h2 && !lvl[1]) |=> !rail_two_on_o)
    else $error("rail two on with pin one low");
  AST_RAIL_PIN: assert property (@(posedge clk_i) disable iff (reset_i)
    (pin_alt_select_i[1] && lvl[1]) |=> rail_two_on_o) else $error("rail two ignores pin one");
  AST_RAIL_SEQ: assert property (@(posedge clk_i) disable iff (reset_i)
    !pin_alt_select_i[1] |=> (rail_two_on_o == $past(power_sequencer_en_i)))
    else $error("rail two not following sequencer");
  AST_LPM: assert property (@(posedge clk_i) disable iff (reset_i)
    bias_low_power_bit_i |=> bias_low_power_req_o) else $error("low power not requested");
  AST_LPM_PIN: assert property (@(posedge clk_i) disable iff (reset_i)
    (pin_alt_select_i[2] && lvl[2]) |=> bias_low_power_req_o) else $error("low-power pin ignored");

  // Main scenarios to be seen at least once
  COV_RISE_IRQ: cover property (@(posedge clk_i) disable iff (reset_i) rise[0] && !s_q.rmask[0] ##2 irq_out_oe_o);
  COV_FALL_IRQ: cover property (@(posedge clk_i) disable iff (reset_i) fall[2] && !s_q.fmask[2] ##2 irq_out_oe_o);
  COV_RAIL_PIN: cover property (@(posedge clk_i) disable iff (reset_i)
    pin_alt_select_i[1] && rail_two_enable_field_i == pin_io_pkg::RAIL_PIN_CODE_A ##1 !rail_two_on_o);
  COV_MASKED_RISE: cover property (@(posedge clk_i) disable iff (reset_i)
    rise[2] && s_q.rmask[2] ##2 !irq_out_oe_o);
  COV_SEQ_RAIL: cover property (@(posedge clk_i) disable iff (reset_i)
    !pin_alt_select_i[1] && power_sequencer_en_i ##1 rail_two_on_o);
endmodule // pin_io_port

// ---- test/pin_host_model.sv ----
// Purpose : Far-side model of the three pins and the interrupt line
// Assumes : Pins and interrupt line carry pull-ups; drivers are low-dominant
// Notes   : The bench commands the external driver through ext_en_i and ext_val_i
`timescale 1ns/10ps
module pin_host_model #(
  parameter int unsigned N = 3
) (
  input  wire logic [N-1:0] pin_out_i,  // Device pin data
  input  wire logic [N-1:0] pin_oe_i,   // Device pin enable
  input  wire logic [N-1:0] ext_en_i,   // External driver enable
  input  wire logic [N-1:0] ext_val_i,  // External driver level
  input  wire logic         irq_n_i,    // Device interrupt data
  input  wire logic         irq_oe_i,   // Device interrupt enable
  output logic      [N-1:0] pin_wire_o, // Resolved pin levels
  output logic              irq_line_o  // Resolved interrupt line
);
  //////////////////////////////////////////////////////////////////////////////
  // Wired-AND with pull-up: a released pin never keeps its last driven value
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      pin_wire_o[i] = (pin_oe_i[i] ? pin_out_i[i] : 1'b1) & (ext_en_i[i] ? ext_val_i[i] : 1'b1);
    end
    irq_line_o = irq_oe_i ? irq_n_i : 1'b1;
  end
endmodule // pin_host_model

// ---- test/pin_io_port_tb.sv ----
// Purpose : Self-checking bench for the three-pin port
// Assumes : Short debounce parameters so the filter settles in tens of cycles
// Notes   : Checks sample 1 ns after an edge so the edge's updates have landed
`timescale 1ns/10ps
module pin_io_port_tb;
  logic       clk_i, reset_i, mask_we, slot, seq_en, lpm_bit, other_irq, rail_on, lpm_req, irq_n, irq_oe, irq_line;
  logic [2:0] pin_in, pin_out, pin_oe, dir, drv, oval, dben, alt, rmask, fmask, rclr, fclr, code;
  logic [2:0] level, alt_o, rflag, fflag, rmask_o, fmask_o, ext_en, ext_val;
  int         miscompares = 0;
  int         check_count = 0;

  //////////////////////////////////////////////////////////////////////////////
  // Clock at 40 MHz
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  pin_io_port #(.TICKS(3), .DIV(4)) DUT (
    .clk_i(clk_i), .reset_i(reset_i), .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
    .pin_dir_i(dir), .pin_drive_type_i(drv), .pin_out_val_i(oval), .input_debounce_en_i(dben),
    .pin_alt_select_i(alt), .input_rise_mask_i(rmask), .input_fall_mask_i(fmask), .mask_we_i(mask_we),
    .rise_clr_i(rclr), .fall_clr_i(fclr), .rail_two_enable_field_i(code), .power_sequencer_slot_i(slot),
    .power_sequencer_en_i(seq_en), .bias_low_power_bit_i(lpm_bit), .other_irq_i(other_irq),
    .pin_input_level_o(level), .pin_alt_select_o(alt_o), .rise_flag_o(rflag), .fall_flag_o(fflag),
    .rise_mask_o(rmask_o), .fall_mask_o(fmask_o), .rail_two_on_o(rail_on), .bias_low_power_req_o(lpm_req),
    .irq_out_n_o(irq_n), .irq_out_oe_o(irq_oe));

  pin_host_model #(.N(3)) host (
    .pin_out_i(pin_out), .pin_oe_i(pin_oe), .ext_en_i(ext_en), .ext_val_i(ext_val),
    .irq_n_i(irq_n), .irq_oe_i(irq_oe), .pin_wire_o(pin_in), .irq_line_o(irq_line));

  //////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic look;
    #1;
  endtask

  task automatic chk(input logic [2:0] got, input logic [2:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  // Flags are sticky, so a one-cycle pulse of both clears empties them
  task automatic clr_flags;
    @(posedge clk_i);
    rclr <= 3'h7;
    fclr <= 3'h7;
    @(posedge clk_i);
    rclr <= 3'h0;
    fclr <= 3'h0;
  endtask

  task automatic load_masks(input logic [2:0] r, input logic [2:0] f);
    @(posedge clk_i);
    rmask   <= r;
    fmask   <= f;
    mask_we <= 1'b1;
    @(posedge clk_i);
    mask_we <= 1'b0;
  endtask

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog: the tests need about 440 cycles
  initial
  begin
    cyc(20000);
    miscompares++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    final_report;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {dir, drv, oval, dben, alt, rmask, fmask, rclr, fclr, code} <= '0;
    {mask_we, slot, seq_en, lpm_bit, other_irq} <= '0;
    reset_i <= 1'b1;
    ext_en  <= 3'h7;
    ext_val <= 3'h0;
    cyc(12);
    reset_i <= 1'b0;
    cyc(2);
    look;
    chk(rmask_o, 3'h7, "rise masks after reset");
    chk(fmask_o, 3'h7, "fall masks after reset");
    chk(3'(irq_oe), 3'h0, "irq after reset");
    // Outputs: pin0 push-pull high, pin1 open-drain high, pin2 push-pull low
    cyc(1);
    drv    <= 3'h5;
    oval   <= 3'h3;
    ext_en <= 3'h0;
    cyc(4);
    look;
    chk(pin_oe, 3'h5, "output enables");
    chk(pin_out & pin_oe, 3'h1, "output levels");
    chk(level, 3'h3, "input level of outputs");
    // Far side pulls pin1 low while it is an output: status follows, no edge
    cyc(1);
    ext_en <= 3'h2;
    cyc(8);
    look;
    chk(level, 3'h1, "input level with far side low");
    chk(rflag | fflag, 3'h0, "no edges while output");
    cyc(1);
    dir     <= 3'h7;
    ext_en  <= 3'h7;
    ext_val <= 3'h0;
    cyc(8);
    look;
    chk(pin_oe, 3'h0, "inputs released");
    load_masks(3'h0, 3'h7);
    clr_flags;
    // Each pin: rise unmasked, fall masked, then both unmasked
    for (int i = 0; i < 3; i++)
    begin
      cyc(1);
      ext_val[i] <= 1'b1;
      cyc(6);
      look;
      chk(rflag, 3'(1 << i), "rise flag");
      chk({irq_oe, irq_n, irq_line}, 3'h4, "irq on rise");
      clr_flags;
      cyc(6);
      look;
      chk(rflag, 3'h0, "single rise event");
      chk(3'(irq_oe), 3'h0, "irq released");
      cyc(1);
      ext_val[i] <= 1'b0;
      cyc(6);
      look;
      chk(fflag, 3'(1 << i), "fall flag");
      chk(3'(irq_oe), 3'h0, "masked fall");
      load_masks(3'h0, 3'h0);
      cyc(2);
      look;
      chk(3'(irq_oe), 3'h1, "fall unmasked");
      chk(rmask_o | fmask_o, 3'h0, "masks loaded");
      clr_flags;
      load_masks(3'h0, 3'h7);
    end
    // Rising edge with its mask set: flagged, but no interrupt
    load_masks(3'h7, 3'h0);
    cyc(1);
    ext_val[2] <= 1'b1;
    cyc(6);
    look;
    chk({rflag[2], 2'(irq_oe)}, 3'h4, "masked rise");
    clr_flags;
    load_masks(3'h0, 3'h7);
    cyc(1);
    other_irq <= 1'b1;
    cyc(3);
    look;
    chk(3'(irq_oe), 3'h1, "other source");
    // Debounce: a short glitch is dropped, a held level arrives late
    cyc(1);
    other_irq  <= 1'b0;
    dben       <= 3'h1;
    ext_val[0] <= 1'b1;
    cyc(3);
    ext_val[0] <= 1'b0;
    cyc(40);
    look;
    chk(rflag, 3'h0, "glitch filtered");
    cyc(1);
    ext_val[0] <= 1'b1;
    cyc(6);
    look;
    chk(rflag, 3'h0, "debounce delays edge");
    cyc(40);
    look;
    chk(rflag, 3'h1, "debounced edge");
    // Alternate modes
    cyc(1);
    dben    <= 3'h0;
    alt     <= 3'h7;
    slot    <= 1'b1;
    ext_val <= 3'h0;
    cyc(3);
    look;
    chk(alt_o, 3'h7, "alt readback");
    chk(pin_oe & pin_out, 3'h1, "slot high on pin0");
    cyc(1);
    slot <= 1'b0;
    cyc(3);
    look;
    chk({pin_oe[0], pin_out[0]}, 3'h2, "slot low on pin0");
    for (int k = 0; k < 16; k++)
    begin
      cyc(1);
      ext_val[1] <= k[3];
      code       <= k[2:0];
      cyc(8);
      look;
      chk(3'(rail_on), 3'(k[3] || (k[2:0] != 3'h4 && k[2:0] != 3'h5)), "rail two enable");
    end
    // Pin one back to a plain pin: rail two follows the sequencer alone
    for (int k = 0; k < 2; k++)
    begin
      cyc(1);
      alt    <= 3'h5;
      seq_en <= k[0];
      cyc(3);
      look;
      chk(3'(rail_on), 3'(k[0]), "rail follows sequencer");
    end
    chk(alt_o, 3'h5, "alt readback after change");
    for (int k = 0; k < 4; k++)
    begin
      cyc(1);
      lpm_bit    <= k[0];
      ext_val[2] <= k[1];
      cyc(8);
      look;
      chk(3'(lpm_req), 3'(k[0] | k[1]), "low-power request");
    end
    final_report;
  end
endmodule // pin_io_port_tb
